// ==== design/rx_recovery.sv ====
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Start verified if at most one of three samples high
// - Failed start resets ticks, restarts search
// - Data bit is majority of ticks 8-10
// - Disagreeing data samples set noise
// - Late start samples only add noise
// - Stop majority zero sets framing error
// - Disagreeing stop samples set noise
// - Noise flag gated by its interrupt enable
// - Framing flag gated by its interrupt enable
// - Parity failure sets flag, gated interrupt
// - Receiver keeps running in wait mode
// - Status access blocked during wait mode
// - Enabled error request wakes processor
// - Break clear enabled: clears stick after break
// - Break protected: accesses leave flags alone
// - Armed two-step clear held through break
module rx_recovery
#(
  parameter int unsigned TICK_DIV = rx_recovery_pkg::TICK_DIV_DEFAULT
)
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Serial line
  input  wire logic        i_rxd,
  // Control bits
  input  wire logic        i_enable,
  input  wire logic        i_nine_bit,
  input  wire logic        i_parity_enable,
  input  wire logic        i_parity_odd,
  input  wire logic        i_noise_irq_enable,
  input  wire logic        i_framing_irq_enable,
  input  wire logic        i_parity_irq_enable,
  // Processor state
  input  wire logic        i_wait_mode,
  input  wire logic        i_debug_break,
  input  wire logic        i_break_clear_enable,
  // Status access: read then write-zero clears flags
  input  wire logic        i_status_read,
  input  wire logic        i_status_clear,
  // Received characters
  output logic             o_rx_valid,
  input  wire logic        i_rx_ready,
  output logic [8:0]       o_rx_data,
  output logic             o_rx_noise,
  output logic             o_rx_framing,
  // Status flags
  output logic             o_noise_flag,
  output logic             o_framing_error_flag,
  output logic             o_parity_error_flag,
  // Interrupt and wake
  output logic             o_error_irq,
  output logic             o_wake
);
  import rx_recovery_pkg::*;

  typedef struct packed
  {
    rx_state_t  state;
    logic [3:0] tick;
    logic [3:0] bitn;
    logic [8:0] shift;
    logic [2:0] smp;
    logic       start_noise;
    logic       char_noise;
    logic       ones;
    logic       noise_flag;
    logic       framing_error_flag;
    logic       parity_error_flag;
    logic       armed;
    logic       push;
    logic [11:0] word;
  } rx_core_t;

  rx_core_t   st_reg;
  rx_core_t   st_next;
  logic [1:0] rxd_sync_reg;
  logic       rxd_prev_reg;
  logic       rxd;
  logic       tick;
  logic [3:0] nbits;
  logic       vote;
  logic       disagree;
  logic       clear_ok;

  rx_word_if #(.W(12)) to_buf ();
  rx_word_if #(.W(12)) from_buf ();

  // Majority of three samples
  function automatic logic majority(input logic [2:0] s);
    majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : majority

  // Samples not unanimous
  function automatic logic mixed(input logic [2:0] s);
    mixed = (s != 3'h0) && (s != 3'h7);
  endfunction : mixed

  rx_tick_gen #(.DIV(TICK_DIV)) u_tick
  (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_enable (i_enable),
    .o_tick   (tick)
  );

  rx_word_buf #(.W(12), .DEPTH(BUF_DEPTH)) u_buf
  (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .in_side  (to_buf),
    .out_side (from_buf)
  );

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rxd_sync_reg <= 2'h3;
      rxd_prev_reg <= 1'b1;
    end
    else
    begin
      rxd_sync_reg <= {rxd_sync_reg[0], i_rxd};
      rxd_prev_reg <= rxd_sync_reg[1];
    end
  end

  assign rxd      = rxd_sync_reg[1];
  assign nbits    = i_nine_bit ? 4'(DATA_BITS_9) : 4'(DATA_BITS_8);
  assign vote     = majority({st_reg.smp[1:0], rxd});
  assign disagree = mixed({st_reg.smp[1:0], rxd});
  // Flag clear allowed outside wait mode, and in break only when break clear is enabled
  assign clear_ok = !i_wait_mode && (!i_debug_break || i_break_clear_enable);

  always_comb
  begin
    st_next      = st_reg;
    st_next.push = 1'b0;
    if (!i_enable)
    begin
      st_next.state = ST_IDLE;
      st_next.tick  = TICK_RESET;
    end
    else
    begin
      case (st_reg.state)
        ST_IDLE:
        begin
          // Falling edge starts tick numbering
          if (rxd_prev_reg && !rxd)
          begin
            st_next.state       = ST_START;
            st_next.tick        = TICK_RESET;
            st_next.start_noise = 1'b0;
            st_next.char_noise  = 1'b0;
            st_next.bitn        = 4'h0;
          end
        end
        ST_START, ST_DATA, ST_STOP:
        begin
          if (tick)
          begin
            st_next.tick = st_reg.tick + 4'h1;
            if (st_reg.state == ST_START &&
                (st_reg.tick == TICK_START_A || st_reg.tick == TICK_START_B))
            begin
              st_next.smp = {st_reg.smp[1:0], rxd};
            end
            if (st_reg.tick == TICK_VOTE_A || st_reg.tick == TICK_VOTE_B)
            begin
              st_next.smp = {st_reg.smp[1:0], rxd};
            end
            if (st_reg.state == ST_START && st_reg.tick == TICK_START_C)
            begin
              if (vote)
              begin
                st_next.state = ST_IDLE;
                st_next.tick  = TICK_RESET;
              end
              else
              begin
                st_next.start_noise = disagree;
              end
            end
            if (st_reg.tick == TICK_VOTE_C)
            begin
              case (st_reg.state)
                ST_START:
                begin
                  // Late samples only add noise
                  st_next.start_noise = st_reg.start_noise | vote | disagree;
                end
                ST_DATA:
                begin
                  st_next.shift      = {vote, st_reg.shift[8:1]};
                  st_next.char_noise = st_reg.char_noise | disagree;
                  st_next.ones       = st_reg.ones ^ vote;
                end
                ST_STOP:
                begin
                  st_next.state = ST_IDLE;
                  st_next.push  = 1'b1;
                  st_next.word  = {disagree | st_reg.char_noise | st_reg.start_noise,
                                   !vote,
                                   i_parity_enable && (st_reg.ones != i_parity_odd),
                                   st_reg.shift >> (4'(DATA_BITS_9) - nbits)};
                end
                default:
                begin
                end
              endcase
            end
            if (st_reg.tick == TICK_LAST)
            begin
              if (st_reg.state == ST_START)
              begin
                st_next.state = ST_DATA;
                st_next.ones  = 1'b0;
              end
              else if (st_reg.state == ST_DATA)
              begin
                st_next.bitn = st_reg.bitn + 4'h1;
                if (st_reg.bitn == nbits - 4'h1)
                begin
                  st_next.state = ST_STOP;
                end
              end
            end
          end
        end
        default:
        begin
          st_next.state = ST_IDLE;
        end
      endcase
    end

    // Two-step clear: read arms, write clears; protected in break unless break clear is enabled
    if (i_status_read && clear_ok)
    begin
      st_next.armed = 1'b1;
    end
    if (i_status_clear && st_reg.armed && clear_ok)
    begin
      st_next.noise_flag         = 1'b0;
      st_next.framing_error_flag = 1'b0;
      st_next.parity_error_flag  = 1'b0;
      st_next.armed              = 1'b0;
    end
    // Set wins over clear
    if (st_reg.push)
    begin
      st_next.noise_flag         = st_reg.noise_flag | st_reg.word[11];
      st_next.framing_error_flag = st_reg.framing_error_flag | st_reg.word[10];
      st_next.parity_error_flag  = st_reg.parity_error_flag | st_reg.word[9];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_reg <= '{state: ST_IDLE, tick: TICK_RESET, noise_flag: FLAG_RESET,
                  framing_error_flag: FLAG_RESET, parity_error_flag: FLAG_RESET, default: '0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Word lost only if buffer full; status flags still record errors
  assign to_buf.valid   = st_reg.push;
  assign to_buf.data    = st_reg.word;
  assign from_buf.ready = i_rx_ready && !i_wait_mode;

  assign o_rx_valid           = from_buf.valid && !i_wait_mode;
  assign o_rx_data            = from_buf.data[8:0];
  assign o_rx_noise           = from_buf.data[11];
  assign o_rx_framing         = from_buf.data[10];
  assign o_noise_flag         = st_reg.noise_flag;
  assign o_framing_error_flag = st_reg.framing_error_flag;
  assign o_parity_error_flag  = st_reg.parity_error_flag;
  assign o_error_irq          = (st_reg.noise_flag && i_noise_irq_enable) ||
                                (st_reg.framing_error_flag && i_framing_irq_enable) ||
                                (st_reg.parity_error_flag && i_parity_irq_enable);
  assign o_wake               = o_error_irq && i_wait_mode;

  sequence s_edge_seen;
    st_reg.state == ST_IDLE && rxd_prev_reg && !rxd && i_enable;
  endsequence

  a_edge_starts : assert property (@(posedge i_clk) disable iff (i_rst)
    s_edge_seen |=> st_reg.state == ST_START && st_reg.tick == TICK_RESET)
    else $error("falling edge did not start search");

  a_start_reject : assert property (@(posedge i_clk) disable iff (i_rst)
    (i_enable && tick && st_reg.state == ST_START && st_reg.tick == TICK_START_C && vote)
    |=> st_reg.state == ST_IDLE)
    else $error("bad start bit accepted");

  a_start_accept : assert property (@(posedge i_clk) disable iff (i_rst)
    (i_enable && tick && st_reg.state == ST_START && st_reg.tick == TICK_START_C && !vote)
    |=> st_reg.state == ST_START && st_reg.start_noise == $past(disagree))
    else $error("good start bit rejected");

  a_stop_framing : assert property (@(posedge i_clk) disable iff (i_rst)
    (i_enable && tick && st_reg.state == ST_STOP && st_reg.tick == TICK_VOTE_C)
    |=> st_reg.push && st_reg.word[10] == !$past(vote) ##1 st_reg.framing_error_flag == st_reg.word[10] || st_reg.framing_error_flag)
    else $error("framing flag wrong");

  a_set_wins : assert property (@(posedge i_clk) disable iff (i_rst)
    (st_reg.push && st_reg.word[11]) |=> st_reg.noise_flag)
    else $error("noise flag lost");

  a_protect_break : assert property (@(posedge i_clk) disable iff (i_rst)
    (i_debug_break && !i_break_clear_enable && !st_reg.push)
    |=> {st_reg.noise_flag, st_reg.framing_error_flag, st_reg.parity_error_flag} ==
        $past({st_reg.noise_flag, st_reg.framing_error_flag, st_reg.parity_error_flag}))
    else $error("flag changed in protected break");

  a_wait_block : assert property (@(posedge i_clk) disable iff (i_rst)
    i_wait_mode |-> !o_rx_valid)
    else $error("access during wait mode");

  a_irq_gate : assert property (@(posedge i_clk) disable iff (i_rst)
    (st_reg.framing_error_flag && i_framing_irq_enable) |-> o_error_irq)
    else $error("framing interrupt missing");

endmodule : rx_recovery

`default_nettype wire

// ==== common/rx_recovery_pkg.sv ====
package rx_recovery_pkg;

  // Sample ticks per bit time and the tick numbers used for voting
  localparam int unsigned TICKS_PER_BIT    = 16;
  localparam logic [3:0]  TICK_START_A     = 4'h3;
  localparam logic [3:0]  TICK_START_B     = 4'h5;
  localparam logic [3:0]  TICK_START_C     = 4'h7;
  localparam logic [3:0]  TICK_VOTE_A      = 4'h8;
  localparam logic [3:0]  TICK_VOTE_B      = 4'h9;
  localparam logic [3:0]  TICK_VOTE_C      = 4'ha;
  localparam logic [3:0]  TICK_LAST        = 4'hf;

  // Character layout
  localparam int unsigned DATA_BITS_8      = 8;
  localparam int unsigned DATA_BITS_9      = 9;
  localparam int unsigned BUF_DEPTH        = 2;

  // Tick divider default: 10 MHz bus, 16 ticks per bit at 9600 baud
  localparam int unsigned CLK_HZ           = 10000000;
  localparam int unsigned BAUD_DEFAULT     = 9600;
  localparam int unsigned TICK_DIV_DEFAULT = CLK_HZ / (BAUD_DEFAULT * TICKS_PER_BIT);

  // Reset values of status and control state
  localparam logic        FLAG_RESET       = 1'b0;
  localparam logic [3:0]  TICK_RESET       = 4'h0;

  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_DATA  = 3'b010,
    ST_STOP  = 3'b011
  } rx_state_t;

endpackage : rx_recovery_pkg

// ==== common/rx_word_if.sv ====
`timescale 1ns/10ps
`default_nettype none

// Word stream carrying a received character and its flags
interface rx_word_if #(parameter int unsigned W = 12);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport source
  (
    output valid,
    output data,
    input  ready
  );

  modport sink
  (
    input  valid,
    input  data,
    output ready
  );
endinterface : rx_word_if

`default_nettype wire

// ==== design/rx_tick_gen.sv ====
`timescale 1ns/10ps
`default_nettype none

// Divider producing the sample-tick enable pulse
module rx_tick_gen
#(
  parameter int unsigned DIV = rx_recovery_pkg::TICK_DIV_DEFAULT
)
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Control
  input  wire logic i_enable,
  // Tick
  output logic      o_tick
);
  import rx_recovery_pkg::*;

  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;

  typedef struct packed
  {
    logic [CW-1:0] cnt;
    logic          tick;
  } tick_state_t;

  tick_state_t st_reg;
  tick_state_t st_next;

  always_comb
  begin
    st_next      = st_reg;
    st_next.tick = 1'b0;
    if (!i_enable)
    begin
      st_next.cnt = '0;
    end
    else if (st_reg.cnt == CW'(DIV - 1))
    begin
      st_next.cnt  = '0;
      st_next.tick = 1'b1;
    end
    else
    begin
      st_next.cnt = st_reg.cnt + CW'(1);
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign o_tick = st_reg.tick;

  a_tick_single : assert property (@(posedge i_clk) disable iff (i_rst)
    (DIV > 1 && o_tick) |=> !o_tick)
    else $error("tick pulse longer than one cycle");

endmodule : rx_tick_gen

`default_nettype wire

// ==== design/rx_word_buf.sv ====
`timescale 1ns/10ps
`default_nettype none

// Two-entry buffer between recovery logic and the reader
module rx_word_buf
#(
  parameter int unsigned W     = 12,
  parameter int unsigned DEPTH = rx_recovery_pkg::BUF_DEPTH
)
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Filling side
  rx_word_if.sink   in_side,
  // Draining side
  rx_word_if.source out_side
);
  import rx_recovery_pkg::*;

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed
  {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
  } buf_state_t;

  buf_state_t   st_reg;
  buf_state_t   st_next;
  logic [W-1:0] mem_reg [DEPTH];
  logic [W-1:0] out_reg;
  logic         push;
  logic         pop;

  assign in_side.ready  = (st_reg.cnt != (AW+1)'(DEPTH));
  assign out_side.valid = (st_reg.cnt != '0);
  assign push           = in_side.valid && in_side.ready;
  assign pop            = out_side.valid && out_side.ready;

  always_comb
  begin
    st_next = st_reg;
    if (push)
    begin
      st_next.wr = (st_reg.wr == AW'(DEPTH - 1)) ? '0 : st_reg.wr + AW'(1);
    end
    if (pop)
    begin
      st_next.rd = (st_reg.rd == AW'(DEPTH - 1)) ? '0 : st_reg.rd + AW'(1);
    end
    st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem_reg[st_reg.wr] <= in_side.data;
    end
  end

  // Registered head word
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      out_reg <= '0;
    end
    else
    begin
      out_reg <= (st_next.cnt == '0) ? out_reg :
                 (push && st_reg.cnt == '0) || (pop && st_reg.cnt == (AW+1)'(1)) ? in_side.data :
                 mem_reg[st_next.rd];
    end
  end

  assign out_side.data = out_reg;

  a_buf_no_overflow : assert property (@(posedge i_clk) disable iff (i_rst)
    st_reg.cnt <= (AW+1)'(DEPTH))
    else $error("buffer count beyond depth");

endmodule : rx_word_buf

`default_nettype wire

// ==== dv/serial_tx_model.sv ====
`timescale 1ns/10ps
`default_nettype none

// Remote transmitter driving the receive line, with per-tick corruption
module serial_tx_model
#(
  parameter int unsigned DIV = 8
)
(
  // Clock
  input  wire logic i_clk,
  // Serial line, idle high
  output var logic  o_rxd
);
  initial o_rxd = 1'b1;

  // One bit time; tick k is inverted where m[k] is set
  task automatic bit_out(input logic v, input logic [15:0] m);
    int c;
    for (c = 0; c < 16 * DIV; c++)
    begin
      @(posedge i_clk);
      #1;
      // Offset of one clock matches synchroniser plus edge detector latency
      o_rxd = v ^ m[(c < 1) ? 0 : (c - 1) / DIV];
    end
  endtask : bit_out

  // Start, data LSB first with bit 0 corrupted by dm, stop, short idle
  task automatic send(input logic [8:0] d, input int nb, input logic [15:0] sm, dm, pm);
    int i;
    bit_out(1'b0, sm);
    for (i = 0; i < nb; i++)
      bit_out(d[i], (i == 0) ? dm : 16'h0000);
    bit_out(1'b1, pm);
    bit_out(1'b1, 16'h0000);
  endtask : send
endmodule : serial_tx_model

`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import rx_recovery_pkg::*;
  localparam int unsigned DIV = 8;

  logic       i_clk, i_rst, i_rxd, i_enable, i_nine_bit, i_parity_enable, i_parity_odd;
  logic       i_noise_irq_enable, i_framing_irq_enable, i_parity_irq_enable;
  logic       i_wait_mode, i_debug_break, i_break_clear_enable, i_status_read, i_status_clear;
  logic       i_rx_ready, o_rx_valid, o_rx_noise, o_rx_framing, o_error_irq, o_wake;
  logic       o_noise_flag, o_framing_error_flag, o_parity_error_flag;
  logic [8:0] o_rx_data, gd;
  logic       gn, gf;
  int         errors, total_checks, k;

  always #50 i_clk = ~i_clk;

  rx_recovery #(.TICK_DIV(DIV)) uut
  (
    .i_clk(i_clk), .i_rst(i_rst), .i_rxd(i_rxd), .i_enable(i_enable), .i_nine_bit(i_nine_bit),
    .i_parity_enable(i_parity_enable), .i_parity_odd(i_parity_odd),
    .i_noise_irq_enable(i_noise_irq_enable), .i_framing_irq_enable(i_framing_irq_enable),
    .i_parity_irq_enable(i_parity_irq_enable), .i_wait_mode(i_wait_mode), .i_debug_break(i_debug_break),
    .i_break_clear_enable(i_break_clear_enable), .i_status_read(i_status_read),
    .i_status_clear(i_status_clear), .o_rx_valid(o_rx_valid), .i_rx_ready(i_rx_ready),
    .o_rx_data(o_rx_data), .o_rx_noise(o_rx_noise), .o_rx_framing(o_rx_framing),
    .o_noise_flag(o_noise_flag), .o_framing_error_flag(o_framing_error_flag),
    .o_parity_error_flag(o_parity_error_flag), .o_error_irq(o_error_irq), .o_wake(o_wake)
  );

  serial_tx_model #(.DIV(DIV)) tx (.i_clk(i_clk), .o_rxd(i_rxd));

  function automatic logic maj(input logic [2:0] p);
    return (p[2] & p[1]) | (p[2] & p[0]) | (p[1] & p[0]);
  endfunction : maj

  function automatic logic noisy(input logic [2:0] p);
    return (p != 3'h0) && (p != 3'h7);
  endfunction : noisy

  // Samples at ticks 8, 9, 10 of a low bit become p
  function automatic logic [15:0] tm(input logic [2:0] p);
    return {5'h00, p[0], p[1], p[2], 8'h00};
  endfunction : tm

  // Start samples at ticks 3, 5, 7 become p; a failed start returns high
  function automatic logic [15:0] smask(input logic [2:0] p, input logic fail);
    return {fail ? 8'hff : 8'h00, p[0], p[1], p[1], p[2], p[2], 3'h0};
  endfunction : smask

  task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
      errors++;
    end
  endtask : check

  task end_sim;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  task automatic step;
    @(posedge i_clk);
    #1;
  endtask : step

  task automatic get_word(output logic [8:0] d, output logic n, output logic f);
    int i;
    i = 0;
    step();
    while (o_rx_valid !== 1'b1 && i < 3000)
    begin
      step();
      i++;
    end
    if (o_rx_valid !== 1'b1)
    begin
      errors++;
      end_sim();
    end
    d = o_rx_data;
    n = o_rx_noise;
    f = o_rx_framing;
    i_rx_ready = 1'b1;
    step();
    i_rx_ready = 1'b0;
  endtask : get_word

  // Status access: read strobe or clear strobe for one cycle
  task automatic strobe(input logic rd);
    if (rd)
      i_status_read = 1'b1;
    else
      i_status_clear = 1'b1;
    step();
    i_status_read = 1'b0;
    i_status_clear = 1'b0;
    step();
  endtask : strobe

  task automatic rx_one(input logic [8:0] d, input logic [15:0] sm, dm, pm, input logic [8:0] ed,
                        input logic en, input logic ef);
    tx.send(d, i_nine_bit ? 9 : 8, sm, dm, pm);
    get_word(gd, gn, gf);
    check("rx_data", gd, ed);
    check("rx_noise", {8'h00, gn}, {8'h00, en});
    check("rx_framing", {8'h00, gf}, {8'h00, ef});
  endtask : rx_one

  initial
  begin
    {i_clk, i_nine_bit, i_parity_enable, i_parity_odd, i_noise_irq_enable} = '0;
    {i_framing_irq_enable, i_parity_irq_enable, i_wait_mode, i_debug_break} = '0;
    {i_break_clear_enable, i_status_read, i_status_clear, i_rx_ready} = '0;
    {errors, total_checks} = '0;
    i_rst = 1'b1;
    i_enable = 1'b1;
    repeat (3) step();
    i_rst = 1'b0;
    repeat (3) step();
    check("reset_state", {o_rx_valid, o_noise_flag, o_framing_error_flag, o_parity_error_flag, o_error_irq}, 0);
    rx_one(9'h0a5, 0, 0, 0, 9'h0a5, 0, 0);
    for (k = 0; k < 8; k++)
      rx_one(9'h0f0, 0, tm(k[2:0]), 0, {8'h78, maj(k[2:0])}, noisy(k[2:0]), 0);
    for (k = 0; k < 8; k++)
      rx_one(9'h03c, 0, 0, tm(~k[2:0]), 9'h03c, noisy(k[2:0]), !maj(k[2:0]));
    for (k = 0; k < 8; k++)
    begin
      if ($countones(k[2:0]) <= 1)
        rx_one(9'h055, smask(k[2:0], 1'b0), 0, 0, 9'h055, k != 0, 0);
      else
      begin
        tx.bit_out(1'b0, smask(k[2:0], 1'b1));
        tx.bit_out(1'b1, 16'h0000);
        rx_one(9'h066, 0, 0, 0, 9'h066, 0, 0);
      end
    end
    rx_one(9'h011, 16'h0700, 0, 0, 9'h011, 1, 0);
    check("flags", {o_noise_flag, o_framing_error_flag, o_parity_error_flag}, 3'h6);
    for (k = 0; k < 8; k++)
    begin
      {i_noise_irq_enable, i_framing_irq_enable, i_parity_irq_enable} = k[2:0];
      step();
      check("error_irq", o_error_irq, |(k[2:0] & 3'h6));
    end
    {i_noise_irq_enable, i_framing_irq_enable, i_parity_irq_enable} = 3'h2;
    i_wait_mode = 1'b1;
    step();
    check("wake", o_wake, 1);
    strobe(1);
    strobe(0);
    check("flags_wait", {o_noise_flag, o_framing_error_flag, o_parity_error_flag}, 3'h6);
    i_wait_mode = 1'b0;
    step();
    check("wake_off", o_wake, 0);
    strobe(1);
    strobe(0);
    check("flags_clr", {o_noise_flag, o_framing_error_flag, o_parity_error_flag}, 0);
    {i_noise_irq_enable, i_framing_irq_enable, i_parity_irq_enable} = 3'h1;
    i_parity_enable = 1'b1;
    for (k = 0; k < 4; k++)
    begin
      i_parity_odd = !k[1];
      strobe(1);
      strobe(0);
      rx_one(k[0] ? 9'h083 : 9'h003, 0, 0, 0, k[0] ? 9'h083 : 9'h003, 0, 0);
      check("parity_flag", o_parity_error_flag, k[0] == k[1]);
      check("parity_irq", o_error_irq, k[0] == k[1]);
    end
    i_parity_enable = 1'b0;
    strobe(1);
    i_debug_break = 1'b1;
    strobe(1);
    strobe(0);
    check("flag_break", o_parity_error_flag, 1);
    i_debug_break = 1'b0;
    strobe(0);
    check("flag_after", o_parity_error_flag, 0);
    rx_one(9'h03c, 0, 0, tm(3'h7), 9'h03c, 0, 1);
    i_break_clear_enable = 1'b1;
    i_debug_break = 1'b1;
    strobe(1);
    strobe(0);
    check("clr_break", o_framing_error_flag, 0);
    i_debug_break = 1'b0;
    i_break_clear_enable = 1'b0;
    step();
    check("clr_kept", o_framing_error_flag, 0);
    i_wait_mode = 1'b1;
    tx.send(9'h0f0, 8, 0, tm(3'h1), 0);
    check("noise_wait", o_noise_flag, 1);
    i_wait_mode = 1'b0;
    get_word(gd, gn, gf);
    check("data_wait", {gn, gd[7:0]}, 9'h1f0);
    for (k = 1; k < 4; k++)
      tx.send(9'h011 * 9'(k), 8, 0, 0, 0);
    for (k = 1; k < 3; k++)
    begin
      get_word(gd, gn, gf);
      check("buffered", gd, 9'h011 * 9'(k));
    end
    repeat (5) step();
    check("dropped", o_rx_valid, 0);
    i_nine_bit = 1'b1;
    rx_one(9'h1a5, 0, 0, 0, 9'h1a5, 0, 0);
    i_nine_bit = 1'b0;
    i_enable = 1'b0;
    i_rst = 1'b1;
    step();
    check("reset_again", {o_rx_valid, o_noise_flag, o_framing_error_flag, o_parity_error_flag}, 0);
    end_sim();
  end
endmodule : tb_top

`default_nettype wire
